// ==== hw/ssw_top.sv ====
// Purpose: supply supervisor, power-on / low-voltage reset and watchdog
// Assumes: comparator flags and bus start pulses synchronous to clk_i
// Notes:   wishbone classic slave, one ack per access, level interrupt
//
// Local design decisions: the Wishbone interface to the registers and the address map.

`timescale 1ns/1ps
`default_nettype none

module ssw_top
	import ssw_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        ref_tick_i,
	input  wire logic        main_lt_bkp_hys_i,
	input  wire logic        main_gt_bkp_hys_i,
	input  wire logic        main_lt_trip_i,
	input  wire logic        main_gt_trip_hys_i,
	input  wire logic        main_above_rst_thr_i,
	input  wire logic        bus_start_i,
	output logic             rst_n_o,
	output logic             on_backup_o,
	output logic             bus_enable_o,
	output logic             nv_access_block_o,
	output logic             irq_o
);

	// register state
	logic [3:0]      power_config_reg;
	logic [EV_W-1:0] int_stat_r;
	logic [EV_W-1:0] int_mask_r;
	logic [EV_W-1:0] int_stat_nxt;
	logic [31:0]     dat_r;
	logic [31:0]     dat_nxt;
	logic            ack_r;
	ssw_state_e      state_r;
	ssw_state_e      state_nxt;
	logic            rst_n_r;
	logic            bkp_out_r;
	logic            bus_en_r;
	logic            nv_block_r;
	logic            irq_r;
	logic            bkp_d_r;
	logic [1:0]      wdt_sel_d_r;
	logic [CNT_W-1:0] wdt_period;

	wire on_backup;
	wire wdt_zero;
	wire rst_zero;

	// bus decode
	wire acc       = wb_cyc_i && wb_stb_i && !ack_r;
	wire wr_lane0  = acc && wb_we_i && wb_sel_i[0];
	wire hit_cfg   = (wb_adr_i == OFS_POWER_CONFIG);
	wire hit_stat  = (wb_adr_i == OFS_STATUS);
	wire hit_istat = (wb_adr_i == OFS_INT_STAT);
	wire hit_imask = (wb_adr_i == OFS_INT_MASK);
	wire wr_cfg    = wr_lane0 && hit_cfg;
	wire wr_istat  = wr_lane0 && hit_istat;
	wire wr_imask  = wr_lane0 && hit_imask;

	// configuration fields
	wire       policy  = power_config_reg[BIT_POLICY];
	wire       bus_off = power_config_reg[BIT_BUS_OFF];
	wire [1:0] wdt_sel = {power_config_reg[BIT_WDT_HI], power_config_reg[BIT_WDT_LO]};
	wire       wdt_en  = (wdt_sel != WDT_SEL_OFF) && !on_backup;

	// sequencer conditions
	wire main_ok    = main_above_rst_thr_i;
	wire in_run     = (state_r == ST_RUN);
	// a start landing in the expiry cycle still refreshes
	wire wdt_expire = in_run && wdt_en && wdt_zero && !bus_start_i;
	// a new period field restarts the count, else the old period runs out first
	wire wdt_sel_chg = (wdt_sel != wdt_sel_d_r);
	// a start only counts while running, never in a timeout
	wire wdt_reload = !in_run || !wdt_en || bus_start_i || wdt_sel_chg;
	// outside a watchdog timeout the reset timer runs only while main is good and not on backup
	wire rst_hold   = !main_ok || on_backup;
	wire rst_load   = in_run || ((state_r != ST_WDT) && rst_hold);
	wire rst_run    = !in_run;

	// period field decode
	always_comb begin
		case (wdt_sel)
			WDT_SEL_SHORT: wdt_period = WDT_SHORT_TICKS;
			WDT_SEL_MID:   wdt_period = WDT_MID_TICKS;
			WDT_SEL_LONG:  wdt_period = WDT_LONG_TICKS;
			default:       wdt_period = WDT_LONG_TICKS;
		endcase
	end

	ssw_supply_switch u_switch (
		.clk_i              (clk_i),
		.rst_i              (rst_i),
		.policy_i           (policy),
		.main_lt_bkp_hys_i  (main_lt_bkp_hys_i),
		.main_gt_bkp_hys_i  (main_gt_bkp_hys_i),
		.main_lt_trip_i     (main_lt_trip_i),
		.main_gt_trip_hys_i (main_gt_trip_hys_i),
		.on_backup_o        (on_backup)
	);

	ssw_tick_timer #(
		.RST_VAL (WDT_LONG_TICKS)
	) u_wdt_tmr (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.load_i     (wdt_reload),
		.load_val_i (wdt_period),
		.run_i      (in_run && wdt_en),
		.tick_i     (ref_tick_i),
		.zero_o     (wdt_zero)
	);

	ssw_tick_timer #(
		.RST_VAL (RST_TICKS)
	) u_rst_tmr (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.load_i     (rst_load),
		.load_val_i (RST_TICKS),
		.run_i      (rst_run),
		.tick_i     (ref_tick_i),
		.zero_o     (rst_zero)
	);

	// reset sequencer: a supply dip always wins over a watchdog timeout
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_POR: begin
				if (rst_zero && !rst_load)
					state_nxt = ST_RUN;
			end
			ST_RUN: begin
				if (rst_hold && !main_ok)
					state_nxt = ST_LVR;
				else if (wdt_expire)
					state_nxt = ST_WDT;
			end
			ST_WDT: begin
				if (!main_ok)
					state_nxt = ST_LVR;
				else if (rst_zero)
					state_nxt = ST_RUN;
			end
			ST_LVR: begin
				if (rst_zero && !rst_load)
					state_nxt = ST_RUN;
			end
			default: state_nxt = ST_POR;
		endcase
	end

	// sequencer and pin flops, reset and block pins taken from the next state so they match it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r    <= ST_POR;
			rst_n_r    <= 1'b0;
			nv_block_r <= 1'b1;
			bkp_out_r  <= 1'b0;
			bus_en_r   <= 1'b1;
			bkp_d_r    <= 1'b0;
			wdt_sel_d_r <= WDT_SEL_OFF;
		end else begin
			state_r    <= state_nxt;
			rst_n_r    <= (state_nxt == ST_RUN);
			nv_block_r <= (state_nxt == ST_POR);
			bkp_out_r  <= on_backup;
			bus_en_r   <= !(on_backup && bus_off);
			bkp_d_r    <= on_backup;
			wdt_sel_d_r <= wdt_sel;
		end
	end

	// sticky events: a new event beats a clear in the same cycle
	wire [EV_W-1:0] ev_set;
	assign ev_set[EV_ENTER_BKP]  = on_backup && !bkp_d_r;
	assign ev_set[EV_LEAVE_BKP]  = !on_backup && bkp_d_r;
	assign ev_set[EV_WDT_EXPIRE] = (state_r == ST_RUN) && (state_nxt == ST_WDT);
	wire [EV_W-1:0] ev_clr = wr_istat ? wb_dat_i[EV_W-1:0] : EV_RST;
	assign int_stat_nxt = ev_set | (int_stat_r & ~ev_clr);

	// register writes and interrupt level
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			power_config_reg <= POWER_CONFIG_RST;
			int_stat_r       <= EV_RST;
			int_mask_r       <= EV_RST;
			irq_r            <= 1'b0;
		end else begin
			if (wr_cfg)
				power_config_reg <= wb_dat_i[3:0];
			if (wr_imask)
				int_mask_r <= wb_dat_i[EV_W-1:0];
			int_stat_r <= int_stat_nxt;
			irq_r      <= |(int_stat_nxt & (wr_imask ? wb_dat_i[EV_W-1:0] : int_mask_r));
		end
	end

	// read mux; unmapped offsets read zero and still ack
	wire [31:0] rd_status = {28'h0, in_run && wdt_en, state_r == ST_POR,
		state_r != ST_RUN, on_backup};
	always_comb begin
		dat_nxt = 32'h0;
		if (hit_cfg)
			dat_nxt = {28'h0, power_config_reg};
		else if (hit_stat)
			dat_nxt = rd_status;
		else if (hit_istat)
			dat_nxt = {29'h0, int_stat_r};
		else if (hit_imask)
			dat_nxt = {29'h0, int_mask_r};
	end

	// single-cycle registered answer, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0;
		end else begin
			ack_r <= acc;
			if (acc)
				dat_r <= dat_nxt;
		end
	end

	assign wb_ack_o          = ack_r;
	assign wb_dat_o          = dat_r;
	assign rst_n_o           = rst_n_r;
	assign on_backup_o       = bkp_out_r;
	assign bus_enable_o      = bus_en_r;
	assign nv_access_block_o = nv_block_r;
	assign irq_o             = irq_r;

	// helper: ticks spent with main good and off backup since last dip or backup, saturating
	logic [CNT_W:0] ok_ticks;
	always_ff @(posedge clk_i) begin
		if (rst_i || rst_hold)
			ok_ticks <= '0;
		else if (ref_tick_i && !ok_ticks[CNT_W])
			ok_ticks <= ok_ticks + (CNT_W+1)'(1);
	end

	// helper: ticks since the last watchdog reload
	logic [CNT_W-1:0] wdt_age;
	always_ff @(posedge clk_i) begin
		if (rst_i || wdt_reload)
			wdt_age <= '0;
		else if (ref_tick_i && in_run && wdt_en && !wdt_zero)
			wdt_age <= wdt_age + CNT_W'(1);
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_run_to_wdt;
		(state_r == ST_RUN) ##1 (state_r == ST_WDT);
	endsequence

	sequence s_lvr_on_backup;
		(state_r == ST_LVR) && on_backup;
	endsequence

	AST_RST_AT_POWER: assert property ($past(rst_i) |-> !rst_n_o && nv_access_block_o)
		else $error("reset output not active after power up");
	AST_POR_BLOCK: assert property ((state_r == ST_POR) |-> nv_access_block_o && !rst_n_o)
		else $error("memory not blocked during power-on reset");
	AST_POR_RELEASE: assert property (
		$rose(rst_n_o) && $past(state_r) == ST_POR |-> ok_ticks >= {1'b0, RST_TICKS})
		else $error("power-on reset released early");
	AST_LVR_RELEASE: assert property (
		$rose(rst_n_o) && $past(state_r) == ST_LVR |-> ok_ticks >= {1'b0, RST_TICKS})
		else $error("low-voltage reset released early");
	AST_BKP_HOLD: assert property (s_lvr_on_backup |=> !rst_n_o)
		else $error("reset released while still on backup");
	AST_WDT_PERIOD: assert property (
		wdt_expire |-> wdt_age == wdt_period)
		else $error("watchdog expired off its selected period");
	AST_WDT_START: assert property (
		in_run && wdt_en && bus_start_i && main_ok |=> wdt_age == '0 && rst_n_o)
		else $error("start did not reload the watchdog");
	AST_WDT_RESET: assert property (s_run_to_wdt |-> !rst_n_o)
		else $error("watchdog expiry did not assert reset");
	AST_WDT_IGNORE: assert property (
		state_r == ST_WDT && bus_start_i && main_ok && !rst_zero |=> state_r == ST_WDT)
		else $error("start shortened the reset timeout");
	AST_WDT_BACKUP: assert property (on_backup && in_run |-> !wdt_expire && state_nxt != ST_WDT)
		else $error("watchdog active on backup");
	AST_BUS_OFF: assert property (
		##1 bus_enable_o == !($past(on_backup) && $past(bus_off)))
		else $error("bus enable does not follow bus-off in backup");
	AST_IRQ_LEVEL: assert property (irq_o == |(int_stat_r & int_mask_r))
		else $error("interrupt level does not match masked status");
	AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	// supply dip and power-on hold
	AST_LVR_ENTER: assert property (in_run && !main_ok |=> !rst_n_o)
		else $error("reset output not asserted on supply dip");
	AST_POR_WAIT: assert property (state_r == ST_POR && !main_ok |=> state_r == ST_POR)
		else $error("power-on reset left while main supply low");
	AST_NV_OPEN: assert property (in_run |-> !nv_access_block_o)
		else $error("memory still blocked after power-on reset");

	// period change restart and sticky status bookkeeping
	AST_WDT_NEW_PERIOD: assert property (wdt_sel_chg |=> wdt_age == '0)
		else $error("period change did not restart the watchdog");
	AST_EXPIRE_STICKY: assert property (ev_set[EV_WDT_EXPIRE] |=> int_stat_r[EV_WDT_EXPIRE])
		else $error("watchdog expiry not recorded in status");
	AST_BKP_EVENT: assert property ($rose(on_backup) |=> int_stat_r[EV_ENTER_BKP])
		else $error("entry to backup not recorded in status");

endmodule : ssw_top

`default_nettype wire

// ==== hw/ssw_pkg.sv ====
// Purpose: shared constants for the supply supervisor and watchdog
// Assumes: a slow reference tick of REF_TICK_HZ times the supervisor periods
// Notes:   register byte offsets are word aligned on a 32-bit bus

package ssw_pkg;

	// slow reference tick rate and the printed periods
	localparam int REF_TICK_HZ    = 1000;
	localparam int RST_TIMEOUT_MS = 250;
	localparam int WDT_SHORT_MS   = 250;
	localparam int WDT_MID_MS     = 750;
	localparam int WDT_LONG_MS    = 1750;

	// tick counts derived from the times above
	localparam int CNT_W = 12;
	localparam logic [CNT_W-1:0] RST_TICKS = CNT_W'(RST_TIMEOUT_MS * REF_TICK_HZ / 1000);
	localparam logic [CNT_W-1:0] WDT_SHORT_TICKS = CNT_W'(WDT_SHORT_MS * REF_TICK_HZ / 1000);
	localparam logic [CNT_W-1:0] WDT_MID_TICKS   = CNT_W'(WDT_MID_MS * REF_TICK_HZ / 1000);
	localparam logic [CNT_W-1:0] WDT_LONG_TICKS  = CNT_W'(WDT_LONG_MS * REF_TICK_HZ / 1000);

	// watchdog period select encodings
	localparam logic [1:0] WDT_SEL_LONG  = 2'h0;
	localparam logic [1:0] WDT_SEL_MID   = 2'h1;
	localparam logic [1:0] WDT_SEL_SHORT = 2'h2;
	localparam logic [1:0] WDT_SEL_OFF   = 2'h3;

	// register byte offsets
	localparam logic [7:0] OFS_POWER_CONFIG = 8'h00;
	localparam logic [7:0] OFS_STATUS       = 8'h04;
	localparam logic [7:0] OFS_INT_STAT     = 8'h08;
	localparam logic [7:0] OFS_INT_MASK     = 8'h0C;

	// power_config_reg fields
	localparam int BIT_POLICY   = 0;
	localparam int BIT_BUS_OFF  = 1;
	localparam int BIT_WDT_LO   = 2;
	localparam int BIT_WDT_HI   = 3;
	localparam logic [3:0] POWER_CONFIG_RST = 4'hC;

	// status fields
	localparam int BIT_ON_BACKUP = 0;
	localparam int BIT_RST_ACT   = 1;
	localparam int BIT_POR_ACT   = 2;
	localparam int BIT_WDT_RUN   = 3;

	// interrupt event bits
	localparam int EV_W          = 3;
	localparam int EV_ENTER_BKP  = 0;
	localparam int EV_LEAVE_BKP  = 1;
	localparam int EV_WDT_EXPIRE = 2;
	localparam logic [EV_W-1:0] EV_RST = 3'h0;

	// reset sequencer states
	typedef enum logic [1:0] {
		ST_POR,
		ST_RUN,
		ST_WDT,
		ST_LVR
	} ssw_state_e;

endpackage : ssw_pkg

// ==== hw/ssw_supply_switch.sv ====
// Purpose: main/backup supply selection under two switchover policies
// Assumes: comparator flags already synchronised to clk_i
// Notes:   starts on main supply after reset

`timescale 1ns/1ps
`default_nettype none

module ssw_supply_switch
	import ssw_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic policy_i,
	input  wire logic main_lt_bkp_hys_i,
	input  wire logic main_gt_bkp_hys_i,
	input  wire logic main_lt_trip_i,
	input  wire logic main_gt_trip_hys_i,
	output logic      on_backup_o
);

	logic on_backup_r;
	logic on_backup_nxt;
	wire  enter_std;
	wire  leave_std;
	wire  enter_bkp;
	wire  leave_bkp;

	// standard needs both comparisons to drop, either one to return
	assign enter_std = main_lt_bkp_hys_i && main_lt_trip_i;
	assign leave_std = main_gt_bkp_hys_i || main_gt_trip_hys_i;
	// legacy simply follows the higher supply, with hysteresis
	assign enter_bkp = policy_i ? main_lt_bkp_hys_i : enter_std;
	assign leave_bkp = policy_i ? main_gt_bkp_hys_i : leave_std;
	assign on_backup_nxt = on_backup_r ? !leave_bkp : enter_bkp;
	assign on_backup_o = on_backup_r;

	// mode flop
	always_ff @(posedge clk_i) begin
		if (rst_i)
			on_backup_r <= 1'b0;
		else
			on_backup_r <= on_backup_nxt;
	end

	AST_STD_ENTER: assert property (@(posedge clk_i) disable iff (rst_i)
		!policy_i && !on_backup_r && !(main_lt_bkp_hys_i && main_lt_trip_i) |=> !on_backup_r)
		else $error("standard policy entered backup without both conditions");
	AST_STD_LEAVE: assert property (@(posedge clk_i) disable iff (rst_i)
		!policy_i && on_backup_r && main_gt_trip_hys_i |=> !on_backup_r)
		else $error("standard policy stayed on backup above trip plus hysteresis");
	AST_LEG_ENTER: assert property (@(posedge clk_i) disable iff (rst_i)
		policy_i && !on_backup_r && main_lt_bkp_hys_i |=> on_backup_r)
		else $error("legacy policy missed entry to backup");
	AST_LEG_LEAVE: assert property (@(posedge clk_i) disable iff (rst_i)
		policy_i && on_backup_r && !main_gt_bkp_hys_i |=> on_backup_r)
		else $error("legacy policy left backup without main above backup");

endmodule : ssw_supply_switch

`default_nettype wire

// ==== hw/ssw_tick_timer.sv ====
// Purpose: down counter of slow reference ticks with load and zero flag
// Assumes: tick_i is a one-cycle pulse
// Notes:   holds at zero until reloaded

`timescale 1ns/1ps
`default_nettype none

module ssw_tick_timer
	import ssw_pkg::*;
#(
	parameter logic [CNT_W-1:0] RST_VAL = RST_TICKS
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             load_i,
	input  wire logic [CNT_W-1:0] load_val_i,
	input  wire logic             run_i,
	input  wire logic             tick_i,
	output logic                  zero_o
);

	logic [CNT_W-1:0] cnt_r;

	// load wins over counting so a refresh is never half taken
	always_ff @(posedge clk_i) begin
		if (rst_i)
			cnt_r <= RST_VAL;
		else if (load_i)
			cnt_r <= load_val_i;
		else if (run_i && tick_i && cnt_r != '0)
			cnt_r <= cnt_r - CNT_W'(1);
	end

	assign zero_o = (cnt_r == '0);

	AST_TMR_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
		load_i |=> cnt_r == $past(load_val_i))
		else $error("timer did not take its load value");

endmodule : ssw_tick_timer

`default_nettype wire

// ==== verification/ssw_host_model.sv ====
// Purpose: host bus master model that refreshes the watchdog with START conditions
// Assumes: one START is a one-cycle pulse in the clk_i domain
// Notes:   a STOP follows every lone START; the block has no STOP input, so it is only counted

`timescale 1ns/1ps
`default_nettype none

module ssw_host_model (
	input  wire logic clk_i,
	output logic      start_o
);
	int stop_cnt;

	// idle bus at time zero
	initial begin
		start_o = 1'b0;
		stop_cnt = 0;
	end

	// one START pulse, then a STOP that is only counted
	task automatic refresh();
		@(posedge clk_i);
		start_o <= 1'b1;
		@(posedge clk_i);
		start_o <= 1'b0;
		stop_cnt++;
	endtask : refresh
endmodule : ssw_host_model

`default_nettype wire

// ==== verification/supply_supervisor_watchdog_bench.sv ====
// Purpose: self-checking bench for the supply supervisor and watchdog
// Assumes: reference tick every 4 clocks, so one tick is 40 ns
// Notes:   periods are checked in ticks with a small margin for tick phase

`timescale 1ns/1ps
`default_nettype none

module supply_supervisor_watchdog_bench
	import ssw_pkg::*;
;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc   = 1'b0;
	logic        we    = 1'b0;
	logic        tick  = 1'b0;
	logic        above = 1'b0;
	logic [3:0]  flg   = 4'h0;
	logic [1:0]  tdiv  = 2'h0;
	logic [7:0]  adr   = 8'h00;
	logic [31:0] dat   = 32'h0;
	logic [31:0] rdat;
	logic [31:0] dat_o;
	logic        ack;
	logic        start;
	logic        rst_n;
	logic        on_bkp;
	logic        bus_en;
	logic        nv_blk;
	logic        irq;
	int          miscompares = 0;
	int          cmp_count   = 0;
	int          t;
	longint      ts;

	// flg is {below backup-hys, above backup+hys, below trip, above trip+hys}
	ssw_top i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.ref_tick_i(tick), .main_lt_bkp_hys_i(flg[3]), .main_gt_bkp_hys_i(flg[2]),
		.main_lt_trip_i(flg[1]), .main_gt_trip_hys_i(flg[0]), .main_above_rst_thr_i(above),
		.bus_start_i(start), .rst_n_o(rst_n), .on_backup_o(on_bkp), .bus_enable_o(bus_en),
		.nv_access_block_o(nv_blk), .irq_o(irq)
	);

	ssw_host_model i_host (
		.clk_i  (clk_i),
		.start_o(start)
	);

	// 100 MHz clock
	always #5 clk_i = ~clk_i;

	// slow reference tick, every 4 clocks to keep the run short
	always @(posedge clk_i) begin
		tdiv <= tdiv + 2'h1;
		tick <= (tdiv == 2'h3);
	end

	// cut a hang short; tests need about 31k clocks
	initial begin
		#800000;
		miscompares++;
		results();
	end

	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : results

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic chkb(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask : chkb

	// tick counts may slip by the tick phase and registered outputs
	task automatic chkt(input int got, input int exp);
		cmp_count++;
		if (got < exp - 3 || got > exp + 3) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chkt

	task automatic clocks(input int c);
		repeat (c) @(posedge clk_i);
	endtask : clocks

	task automatic ticks(input int n);
		clocks(4 * n);
	endtask : ticks

	// classic single cycle; request held until ack is sampled high, a hang ends in the bench time limit
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		rdat = dat_o;
		cyc <= 1'b0;
		we <= 1'b0;
	endtask : wb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		chk(rdat, exp);
	endtask : rd

	task automatic flags(input logic [3:0] f);
		@(posedge clk_i);
		flg <= f;
	endtask : flags

	// waits for the reset output level; tk is ticks since s
	task automatic until_rst(input logic v, input int lim, input longint s, output int tk);
		while (rst_n !== v && ($time - s) < lim * 40) begin
			@(posedge clk_i);
		end
		tk = int'(($time - s) / 40);
	endtask : until_rst

	// refresh twice, then let it expire; a START during the timeout changes nothing
	task automatic wdt_case(input logic [1:0] s, input int per);
		longint tf;
		wr(OFS_POWER_CONFIG, {28'h0, s, 2'b00});
		rd(OFS_STATUS, 32'h8);
		i_host.refresh();
		ticks(per - 40);
		i_host.refresh();
		ts = $time;
		until_rst(1'b0, per + 20, ts, t);
		chkt(t, per);
		tf = $time;
		ticks(100);
		i_host.refresh();
		until_rst(1'b1, 300, tf, t);
		chkt(t, int'(RST_TICKS));
		$display("test watchdog period %0d done", per);
	endtask : wdt_case

	// main sequence
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		above <= 1'b1;
		ts = $time;
		clocks(2);
		chkb(rst_n, 1'b0);
		chkb(nv_blk, 1'b1);
		rd(OFS_POWER_CONFIG, 32'hC);
		rd(OFS_STATUS, 32'h6);
		wr(8'h10, 32'hF);
		rd(8'h10, 32'h0);
		until_rst(1'b1, 300, ts, t);
		chkt(t, int'(RST_TICKS));
		clocks(2);
		chkb(nv_blk, 1'b0);
		$display("test power-on reset done");

		wdt_case(WDT_SEL_SHORT, int'(WDT_SHORT_TICKS));
		rd(OFS_INT_STAT, 32'h4);
		wr(OFS_INT_STAT, 32'h4);
		rd(OFS_INT_STAT, 32'h0);
		wdt_case(WDT_SEL_MID, int'(WDT_MID_TICKS));
		wdt_case(WDT_SEL_LONG, int'(WDT_LONG_TICKS));
		wr(OFS_POWER_CONFIG, 32'hC);
		i_host.refresh();
		ticks(300);
		chkb(rst_n, 1'b1);
		rd(OFS_STATUS, 32'h0);
		wr(OFS_INT_STAT, 32'h7);
		$display("test watchdog off done");

		// standard policy needs both conditions to enter, either to leave
		flags(4'b1000);
		clocks(4);
		chkb(on_bkp, 1'b0);
		flags(4'b1010);
		clocks(4);
		chkb(on_bkp, 1'b1);
		rd(OFS_STATUS, 32'h1);
		rd(OFS_INT_STAT, 32'h1);
		chkb(irq, 1'b0);
		wr(OFS_INT_MASK, 32'h1);
		clocks(2);
		chkb(irq, 1'b1);
		wr(OFS_INT_STAT, 32'h1);
		clocks(2);
		chkb(irq, 1'b0);
		flags(4'b0001);
		clocks(4);
		chkb(on_bkp, 1'b0);
		flags(4'b1010);
		clocks(4);
		chkb(on_bkp, 1'b1);
		flags(4'b0100);
		clocks(4);
		chkb(on_bkp, 1'b0);
		$display("test standard policy done");

		// legacy policy follows the backup comparison only
		wr(OFS_POWER_CONFIG, 32'hD);
		flags(4'b1000);
		clocks(4);
		chkb(on_bkp, 1'b1);
		chkb(bus_en, 1'b1);
		flags(4'b0001);
		clocks(4);
		chkb(on_bkp, 1'b1);
		wr(OFS_POWER_CONFIG, 32'hF);
		clocks(2);
		chkb(bus_en, 1'b0);
		@(posedge clk_i);
		above <= 1'b0;
		clocks(3);
		chkb(rst_n, 1'b0);
		@(posedge clk_i);
		above <= 1'b1;
		ticks(300);
		chkb(rst_n, 1'b0);
		flags(4'b0100);
		ts = $time;
		clocks(4);
		chkb(on_bkp, 1'b0);
		chkb(bus_en, 1'b1);
		until_rst(1'b1, 300, ts, t);
		chkt(t, int'(RST_TICKS));
		$display("test legacy policy and low voltage done");

		// watchdog armed but asleep on backup
		wr(OFS_POWER_CONFIG, 32'h9);
		flags(4'b1000);
		clocks(4);
		i_host.refresh();
		ticks(400);
		chkb(rst_n, 1'b1);
		rd(OFS_STATUS, 32'h1);
		flags(4'b0100);
		wr(OFS_POWER_CONFIG, 32'hC);
		chk(32'(i_host.stop_cnt), 32'hB);
		$display("test watchdog on backup done");
		results();
	end
endmodule : supply_supervisor_watchdog_bench

`default_nettype wire
